/* File: include/aem_pkg.sv */
/*
 * Shared constants and types for the asynchronous external memory controller:
 * clock figures, config field layout, reset values, states and carriers.
 * Assumes a single core clock; every count is in whole periods of that clock.
 */
package aem_pkg;

    // ----------------------------------------------------------------
    // clock figures
    // ----------------------------------------------------------------
    localparam int CORE_CLK_PERIOD_PS = 10000;
    localparam int REF_FREQ_KHZ = 19200;
    // one bus period T is one core clock period
    localparam int BUS_PERIOD_PS = CORE_CLK_PERIOD_PS;
    localparam int T_CYCLES = (BUS_PERIOD_PS + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 6;
    localparam int NUM_SEL = 4;

    // ----------------------------------------------------------------
    // config register fields and map
    // ----------------------------------------------------------------
    localparam int PAGE_SIZE_HI = 30;
    localparam int PAGE_SIZE_LO = 28;
    localparam int PRECHARGE_HI = 27;
    localparam int PRECHARGE_LO = 24;
    localparam int RECOVERY_HI = 23;
    localparam int RECOVERY_LO = 20;
    localparam int HOLD_HI = 19;
    localparam int HOLD_LO = 16;
    localparam int DELTA_WR_HI = 15;
    localparam int DELTA_WR_LO = 12;
    localparam int DELTA_RD_HI = 10;
    localparam int DELTA_RD_LO = 8;
    localparam int WAIT_WR_HI = 7;
    localparam int WAIT_WR_LO = 4;
    localparam int WAIT_RD_HI = 3;
    localparam int WAIT_RD_LO = 0;
    // bits 31 and 11 are reserved and read as zero
    localparam logic [31:0] CFG_MASK = 32'h7FFF_F7FF;
    // minimum legal setting: hold, write delta, read delta at 1
    localparam logic [31:0] CFG_RESET = 32'h0001_1100;

    localparam logic [2:0] IDX_ROM0_CFG = 3'h0;
    localparam logic [2:0] IDX_ROM1_CFG = 3'h1;
    localparam logic [2:0] IDX_RAM0_CFG = 3'h2;
    localparam logic [2:0] IDX_RAM1_CFG = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;

    localparam logic [1:0] SEL_ROM1 = 2'h1;
    localparam logic [1:0] SEL_RAM1 = 2'h3;

    // ----------------------------------------------------------------
    // fixed gaps after an access and the one-period lead, in cycles minus one
    // ----------------------------------------------------------------
    // read gap covers the two-stage data synchroniser
    localparam logic [CNT_W-1:0] READ_GAP_M1 = 6'h01;
    localparam logic [CNT_W-1:0] WRITE_GAP_M1 = 6'h00;
    localparam logic [CNT_W-1:0] ONE_M1 = 6'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PAIR_NAND_SDRAM = 2'b00,
        PAIR_BURST_PSRAM = 2'b01,
        PAIR_BURST_SDRAM = 2'b10,
        PAIR_RESERVED = 2'b11
    } aem_pairing_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LEAD = 3'b010,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b100,
        ST_GAP = 3'b101
    } aem_state_t;

    typedef struct packed {
        logic write;
        logic [1:0] sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aem_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic write_n;
        logic output_enable_n;
    } aem_bus_t;

endpackage

/* File: hw/aem_sync.sv */
/*
 * Two-stage synchroniser for the external data bus inputs.
 * Assumes the pins are asynchronous to core_clk; only stage two is read.
 */
`timescale 1ns/1ps
module aem_sync
    import aem_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] pin_in,
    output logic [DATA_W-1:0] sync_out
);

    logic [DATA_W-1:0] meta_r;
    logic [DATA_W-1:0] sync_r;

    // ----------------------------------------------------------------
    // per-bit two-flop stages
    // ----------------------------------------------------------------
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
        always_ff @(posedge core_clk) begin
            if (rst) begin
                meta_r[i] <= 1'b0;
                sync_r[i] <= 1'b0;
            end else begin
                meta_r[i] <= pin_in[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end

    assign sync_out = sync_r;

endmodule

/* File: hw/aem_timer.sv */
/*
 * Down-counter that times each bus phase.
 * Assumes load is pulsed on entry to a phase with its length minus one.
 */
`timescale 1ns/1ps
module aem_timer
    import aem_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic done
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = load_val;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign done = (count_r == '0);

endmodule

/* File: hw/aem_ctrl.sv */
/*
 * Asynchronous external memory controller for the first external bus:
 * four chip selects, per-select timing config, write and read strobes.
 * Assumes requests come from logic on core_clk; data inputs are pins.
 */
// Contract
// - only NAND+SDRAM or burst+PSRAM pairings
// - four active-low selects, two shared with GPIO
// - extra cycles are delta minus one
// - config field layout and minimum setting
// - idle cycle between read and write
// - write strobe one period after select
// - write strobe after select, lasts 1+mw+nw
// - address held 1+hold after write strobe
// - select held 1+hold after write strobe
// - write select lasts 3+mw+nw+hw
// - keepers hold last written data
// - write select follows address by 1+recovery
// - read select follows address by recovery
// - read strobe lasts 1+mr+nr
// - read strobe one period after select
// - read select lasts 2+mr+nr
// - read select ends with read strobe
// - write data valid one period after select
// - counts in system clock periods
`timescale 1ns/1ps
module aem_ctrl
    import aem_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] pairing_mode,
    input wire logic rom_select1_pin_en,
    input wire logic ram_select1_pin_en,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_idx,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic req_valid,
    output logic req_ready,
    input wire aem_req_t req,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rom_select0_n,
    output logic rom_select1_n,
    output logic ram_select0_n,
    output logic ram_select1_n,
    output aem_bus_t bus_out,
    input wire logic [DATA_W-1:0] bus_din
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] minus_one(input logic [3:0] f);
        minus_one = (f == 4'h0) ? '0 : CNT_W'(f - 4'h1);
    endfunction

    function automatic logic [CNT_W-1:0] strobe_m1(input logic [31:0] c, input logic wr);
        if (wr) begin
            strobe_m1 = minus_one(c[DELTA_WR_HI:DELTA_WR_LO]) + CNT_W'(c[WAIT_WR_HI:WAIT_WR_LO]);
        end else begin
            strobe_m1 = minus_one({1'b0, c[DELTA_RD_HI:DELTA_RD_LO]})
                + CNT_W'(c[WAIT_RD_HI:WAIT_RD_LO]);
        end
    endfunction

    function automatic logic [CNT_W-1:0] recovery(input logic [31:0] c);
        recovery = CNT_W'(c[RECOVERY_HI:RECOVERY_LO]);
    endfunction

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [31:0] cfg_r [NUM_SEL];
    logic [31:0] cfg_nxt [NUM_SEL];
    logic [31:0] cfg_rdata_nxt;

    always_comb begin
        for (int i = 0; i < NUM_SEL; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        if (cfg_wr && cfg_idx < IDX_STATUS) begin
            cfg_nxt[cfg_idx[1:0]] = cfg_wdata & CFG_MASK;
        end
    end

    // ----------------------------------------------------------------
    // access state
    // ----------------------------------------------------------------
    aem_state_t state_r;
    aem_state_t state_nxt;
    aem_req_t cur_r;
    aem_req_t cur_nxt;
    logic [31:0] cur_cfg_r;
    logic [31:0] cur_cfg_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic rsp_err_r;
    logic rsp_err_nxt;
    logic [NUM_SEL-1:0] sel_n_r;
    logic [NUM_SEL-1:0] sel_n_nxt;
    aem_bus_t bus_r;
    aem_bus_t bus_nxt;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_done;
    logic [DATA_W-1:0] din_sync;
    logic refuse;
    logic sel_active;

    aem_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    aem_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(bus_din),
        .sync_out(din_sync)
    );

    // unsupported pairing or a select whose pin is lent to GPIO is refused
    always_comb begin
        refuse = (pairing_mode == PAIR_BURST_SDRAM) || (pairing_mode == PAIR_RESERVED);
        if (req.sel == SEL_ROM1 && !rom_select1_pin_en) begin
            refuse = 1'b1;
        end
        if (req.sel == SEL_RAM1 && !ram_select1_pin_en) begin
            refuse = 1'b1;
        end
    end

    assign req_ready = (state_r == ST_IDLE);

    // ----------------------------------------------------------------
    // phase sequencing; each phase length is in bus periods
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        cur_cfg_nxt = cur_cfg_r;
        rdata_nxt = rdata_r;
        rsp_valid_nxt = 1'b0;
        rsp_err_nxt = 1'b0;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_r)
            ST_IDLE: begin
                if (req_valid) begin
                    if (refuse) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_err_nxt = 1'b1;
                    end else begin
                        cur_nxt = req;
                        cur_cfg_nxt = cfg_r[req.sel];
                        tmr_load = 1'b1;
                        if (req.write) begin
                            state_nxt = ST_SETUP;
                            tmr_val = recovery(cfg_r[req.sel]);
                        end else if (recovery(cfg_r[req.sel]) == '0) begin
                            state_nxt = ST_LEAD;
                            tmr_val = ONE_M1;
                        end else begin
                            state_nxt = ST_SETUP;
                            tmr_val = recovery(cfg_r[req.sel]) - 1'b1;
                        end
                    end
                end
            end
            ST_SETUP: begin
                if (tmr_done) begin
                    state_nxt = ST_LEAD;
                    tmr_load = 1'b1;
                    tmr_val = ONE_M1;
                end
            end
            ST_LEAD: begin
                // one period of select before either strobe
                if (tmr_done) begin
                    state_nxt = ST_STROBE;
                    tmr_load = 1'b1;
                    tmr_val = strobe_m1(cur_cfg_r, cur_r.write);
                end
            end
            ST_STROBE: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (cur_r.write) begin
                        state_nxt = ST_HOLD;
                        // hold phase lasts 1+hw periods, i.e. the field itself
                        tmr_val = CNT_W'(cur_cfg_r[HOLD_HI:HOLD_LO]) - CNT_W'(1);
                        if (cur_cfg_r[HOLD_HI:HOLD_LO] == 4'h0) begin
                            tmr_val = ONE_M1;
                        end
                    end else begin
                        state_nxt = ST_GAP;
                        tmr_val = READ_GAP_M1;
                    end
                end
            end
            ST_HOLD: begin
                if (tmr_done) begin
                    state_nxt = ST_GAP;
                    tmr_load = 1'b1;
                    tmr_val = WRITE_GAP_M1;
                end
            end
            ST_GAP: begin
                // bus idle here separates any read from a following write
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                    rsp_valid_nxt = 1'b1;
                    if (!cur_r.write) begin
                        rdata_nxt = din_sync;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // pin drive, registered from the next state
    // ----------------------------------------------------------------
    always_comb begin
        sel_active = 1'b0;
        sel_n_nxt = {NUM_SEL{1'b1}};
        bus_nxt = bus_r;
        bus_nxt.write_n = 1'b1;
        bus_nxt.output_enable_n = 1'b1;
        bus_nxt.doe = 1'b0;
        if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
            bus_nxt.addr = cur_nxt.addr;
        end
        case (state_nxt)
            ST_LEAD: begin
                sel_active = 1'b1;
                if (cur_nxt.write) begin
                    bus_nxt.dout = cur_nxt.wdata;
                end
            end
            ST_STROBE: begin
                sel_active = 1'b1;
                bus_nxt.write_n = !cur_nxt.write;
                bus_nxt.output_enable_n = cur_nxt.write;
                bus_nxt.doe = cur_nxt.write;
            end
            ST_HOLD: begin
                sel_active = 1'b1;
            end
            default: begin
                sel_active = 1'b0;
            end
        endcase
        if (sel_active) begin
            sel_n_nxt[cur_nxt.sel] = 1'b0;
        end
    end

    always_comb begin
        cfg_rdata_nxt = 32'h0000_0000;
        if (cfg_idx < IDX_STATUS) begin
            cfg_rdata_nxt = cfg_r[cfg_idx[1:0]];
        end else if (cfg_idx == IDX_STATUS) begin
            cfg_rdata_nxt = {28'h000_0000, (state_r != ST_IDLE), state_r};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                cfg_r[i] <= CFG_RESET;
            end
            state_r <= ST_IDLE;
            cur_r <= '0;
            cur_cfg_r <= CFG_RESET;
            rdata_r <= '0;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            sel_n_r <= {NUM_SEL{1'b1}};
            bus_r <= '{addr: '0, dout: '0, doe: 1'b0, write_n: 1'b1, output_enable_n: 1'b1};
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_r <= cfg_nxt;
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            cur_cfg_r <= cur_cfg_nxt;
            rdata_r <= rdata_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            sel_n_r <= sel_n_nxt;
            bus_r <= bus_nxt;
            cfg_rdata <= cfg_rdata_nxt;
        end
    end

    assign rom_select0_n = sel_n_r[0];
    assign rom_select1_n = sel_n_r[1];
    assign ram_select0_n = sel_n_r[2];
    assign ram_select1_n = sel_n_r[3];
    assign bus_out = bus_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_err = rsp_err_r;
    assign rsp_rdata = rdata_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic any_select_n;
    logic [7:0] cs_cnt_r;
    logic [7:0] st_cnt_r;
    logic [7:0] hold_cnt_r;
    logic [7:0] setup_cnt_r;
    logic [7:0] exp_strobe;
    logic [7:0] exp_hold;
    logic [7:0] exp_setup;

    assign any_select_n = &sel_n_r;
    assign exp_strobe = 8'(strobe_m1(cur_cfg_r, cur_r.write)) + 8'h01;
    assign exp_hold = (cur_cfg_r[HOLD_HI:HOLD_LO] == 4'h0) ? 8'h01
        : 8'(cur_cfg_r[HOLD_HI:HOLD_LO]);
    assign exp_setup = 8'(recovery(cur_cfg_r)) + (cur_r.write ? 8'h01 : 8'h00);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_cnt_r <= 8'h00;
            st_cnt_r <= 8'h00;
            hold_cnt_r <= 8'h00;
            setup_cnt_r <= 8'h00;
        end else begin
            cs_cnt_r <= !any_select_n ? cs_cnt_r + 8'h01 : 8'h00;
            st_cnt_r <= !(bus_r.write_n && bus_r.output_enable_n) ? st_cnt_r + 8'h01 : 8'h00;
            hold_cnt_r <= (!any_select_n && bus_r.write_n && st_cnt_r != 8'h00)
                || (!any_select_n && hold_cnt_r != 8'h00) ? hold_cnt_r + 8'h01 : 8'h00;
            setup_cnt_r <= (state_r == ST_SETUP) ? setup_cnt_r + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_idle_high;
        state_r == ST_IDLE |-> any_select_n && bus_r.write_n && bus_r.output_enable_n;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("bus not idle high");

    property p_gap;
        $rose(any_select_n) |=> any_select_n;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle between accesses");

    property p_rd_after_cs;
        $fell(bus_r.output_enable_n) |-> !$past(any_select_n) && $past(any_select_n, 2);
    endproperty
    a_rd_after_cs: assert property (p_rd_after_cs) else $error("read strobe not 1T after select");

    property p_wr_after_cs;
        $fell(bus_r.write_n) |-> !$past(any_select_n) && $past(any_select_n, 2) && bus_r.doe;
    endproperty
    a_wr_after_cs: assert property (p_wr_after_cs) else $error("write strobe or data misplaced");

    property p_rd_cs_end;
        $rose(bus_r.output_enable_n) |-> $rose(any_select_n);
    endproperty
    a_rd_cs_end: assert property (p_rd_cs_end) else $error("read select not released with strobe");

    property p_strobe_len;
        ($rose(bus_r.output_enable_n) || $rose(bus_r.write_n)) |-> st_cnt_r == exp_strobe;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");

    property p_wr_cs_len;
        $rose(any_select_n) && cur_r.write |-> cs_cnt_r == exp_strobe + exp_hold + 8'h01;
    endproperty
    a_wr_cs_len: assert property (p_wr_cs_len) else $error("write select length wrong");

    property p_rd_cs_len;
        $rose(any_select_n) && !cur_r.write |-> cs_cnt_r == exp_strobe + 8'h01;
    endproperty
    a_rd_cs_len: assert property (p_rd_cs_len) else $error("read select length wrong");

    property p_wr_hold;
        $rose(any_select_n) && cur_r.write |-> hold_cnt_r == exp_hold;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold length wrong");

    property p_setup;
        $fell(any_select_n) |-> setup_cnt_r == exp_setup;
    endproperty
    a_setup: assert property (p_setup) else $error("address to select delay wrong");

    property p_done;
        req_valid && req_ready && !refuse |-> ##[4:200] rsp_valid;
    endproperty
    a_done: assert property (p_done) else $error("access did not complete");

    c_write: cover property ($rose(bus_r.write_n));
    c_read: cover property ($rose(bus_r.output_enable_n));
    c_refuse: cover property (rsp_valid && rsp_err);
    c_rd_wr: cover property ($rose(bus_r.output_enable_n) ##[1:10] $fell(bus_r.write_n));

endmodule

/* File: verif/aem_mem_model.sv */
/*
 * Async memory on the far side of aem_ctrl: 16 words by addr[3:0].
 * Assumes the controller's registered pins, sampled on core_clk.
 */
`timescale 1ns/1ps
module aem_mem_model
    import aem_pkg::*;
(
    input wire logic core_clk,
    input wire logic [3:0] sel_n,
    input wire aem_bus_t bus_in,
    output logic [DATA_W-1:0] din
);
    logic [DATA_W-1:0] mem_r [16];
    logic [DATA_W-1:0] last_r = 16'h5A5A;
    logic drive;
    assign drive = (sel_n != 4'hF) && !bus_in.output_enable_n;
    // released lines flip, so a stale word never passes for a read
    assign din = drive ? mem_r[bus_in.addr[3:0]] : ~last_r;
    always @(posedge core_clk) begin
        if (drive)
            last_r <= mem_r[bus_in.addr[3:0]];
        if (sel_n != 4'hF && !bus_in.write_n && bus_in.doe)
            mem_r[bus_in.addr[3:0]] <= bus_in.dout;
    end
endmodule

/* File: verif/aem_ctrl_bench.sv */
/*
 * Bench for aem_ctrl: config, timed accesses on every select, refusals.
 * Assumes aem_mem_model on the pins and one 100 MHz clock.
 */
`timescale 1ns/1ps
module aem_ctrl_bench;
    import aem_pkg::*;
    logic core_clk, rst, cfg_wr, req_valid, req_ready, rsp_valid, rsp_err;
    logic rom_select1_pin_en, ram_select1_pin_en;
    logic rom_select0_n, rom_select1_n, ram_select0_n, ram_select1_n;
    logic [1:0] pairing_mode;
    logic [2:0] cfg_idx;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [DATA_W-1:0] rsp_rdata, bus_din;
    logic [3:0] sel_n;
    aem_req_t req;
    aem_bus_t bus_out;
    int n_fail = 0;
    int checks = 0;
    int rec[4] = '{0, 15, 2, 0};
    int hld[4] = '{0, 14, 2, 0};
    int wmid[4] = '{0, 29, 4, 0};
    int rmid[4] = '{0, 21, 2, 0};
    assign sel_n = {ram_select1_n, ram_select0_n, rom_select1_n, rom_select0_n};
    aem_ctrl aem_ctrl_inst (.core_clk(core_clk), .rst(rst), .pairing_mode(pairing_mode),
        .rom_select1_pin_en(rom_select1_pin_en), .ram_select1_pin_en(ram_select1_pin_en),
        .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .rom_select0_n(rom_select0_n),
        .rom_select1_n(rom_select1_n), .ram_select0_n(ram_select0_n),
        .ram_select1_n(ram_select1_n), .bus_out(bus_out), .bus_din(bus_din));
    aem_mem_model aem_mem_model_inst (.core_clk(core_clk), .sel_n(sel_n), .bus_in(bus_out),
        .din(bus_din));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cfg_write(input logic [2:0] i, input logic [31:0] d);
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_idx <= i;
        cfg_wdata <= d;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic cfg_check(input logic [2:0] i, input logic [31:0] e);
        @(posedge core_clk);
        cfg_idx <= i;
        @(posedge core_clk);
        #1;
        chk("cfg_rdata", e, cfg_rdata);
    endtask
    // one access, timed cycle by cycle from the take edge
    task automatic access(input logic wr, input logic [1:0] s, input logic [15:0] d,
                          input int r, input int mid, input int hw, input logic refd);
        int cs_on, cs_len, st_on, st_len, bad, k;
        logic done;
        cs_on = 0;
        cs_len = 0;
        st_on = 0;
        st_len = 0;
        bad = 0;
        done = 1'b0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{wr, s, {22'h0, s}, d};
        #1;
        for (k = 0; k < 20 && req_ready !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        req_valid <= 1'b0;
        // sample k looks at the pins just after edge k-1 counted from the take edge
        for (k = 1; k < 100 && !done; k++) begin
            if (k > 1)
                @(posedge core_clk);
            #1;
            if (sel_n[s] === 1'b0) begin
                cs_on = (cs_on == 0) ? k : cs_on;
                cs_len++;
                bad += (bus_out.addr !== {22'h0, s});
            end
            if ((wr ? bus_out.write_n : bus_out.output_enable_n) === 1'b0) begin
                st_on = (st_on == 0) ? k : st_on;
                st_len++;
            end
            bad += ((sel_n | (4'h1 << s)) !== 4'hF);
            bad += (wr ? bus_out.output_enable_n !== 1'b1 : bus_out.write_n !== 1'b1);
            bad += (bus_out.doe === 1'b1 && (!wr || bus_out.write_n || bus_out.dout !== d));
            done = (rsp_valid === 1'b1);
        end
        chk("rsp_valid", 32'h1, {31'h0, done});
        chk("rsp_err", {31'h0, refd}, {31'h0, rsp_err});
        chk("bus_rules", 0, bad);
        if (refd)
            chk("cs_on", 0, cs_on);
        else begin
            chk("cs_on", wr ? 2 + r : 1 + r, cs_on);
            chk("cs_len", wr ? 3 + mid + hw : 2 + mid, cs_len);
            chk("st_on", cs_on + 1, st_on);
            chk("st_len", 1 + mid, st_len);
            chk("cs_tail", wr ? 1 + hw : 0, cs_on + cs_len - st_on - st_len);
            chk("data", {16'h0, d}, {16'h0, wr ? bus_out.dout : rsp_rdata});
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input int n);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            cfg_check(3'(i), 32'h0001_1100);
        chk("idle", 6'h3F, {sel_n, bus_out.write_n, bus_out.output_enable_n});
    endtask
    task automatic t_mask();
        cfg_write(3'h1, 32'hFFFF_FFFF);
        cfg_check(3'h1, 32'h7FFF_F7FF);
        cfg_write(3'h2, 32'h0023_3221);
    endtask
    task automatic t_sweep();
        for (int s = 0; s < 4; s++) begin
            access(1'b1, 2'(s), 16'(16'hC3A0 + s), rec[s], wmid[s], hld[s], 1'b0);
            access(1'b0, 2'(s), 16'(16'hC3A0 + s), rec[s], rmid[s], 0, 1'b0);
        end
    endtask
    task automatic t_refuse();
        @(posedge core_clk);
        rom_select1_pin_en <= 1'b0;
        ram_select1_pin_en <= 1'b0;
        access(1'b1, 2'h1, 16'h0, 0, 0, 0, 1'b1);
        access(1'b0, 2'h3, 16'h0, 0, 0, 0, 1'b1);
        @(posedge core_clk);
        rom_select1_pin_en <= 1'b1;
        ram_select1_pin_en <= 1'b1;
        for (int p = 2; p < 4; p++) begin
            @(posedge core_clk);
            pairing_mode <= 2'(p);
            access(1'b1, 2'h0, 16'h0, 0, 0, 0, 1'b1);
        end
        @(posedge core_clk);
        pairing_mode <= 2'h0;
        access(1'b1, 2'h0, 16'h1234, 0, 0, 0, 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_idx = 3'h0;
        cfg_wdata = 32'h0;
        req_valid = 1'b0;
        req = '0;
        pairing_mode = 2'h1;
        rom_select1_pin_en = 1'b1;
        ram_select1_pin_en = 1'b1;
        t_reset(12);
        t_mask();
        t_sweep();
        t_refuse();
        t_reset(2);
        final_report();
    end
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule
